// File: rtl/clock_out_divider.sv
/*
  Clock-output divider: picks one of three prescaled clock enables by
  the select code and toggles the output on each pick (divide by two).
  Assumes the enables are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module clock_out_divider (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_enable,
  input wire logic [1:0] i_select,
  input wire logic i_sys_tick,
  input wire logic i_phy_tick,
  input wire logic i_afe_tick,
  // Output
  output logic o_clock_out
);
  import test_mode_pkg::*;

  logic out_level;
  logic next_out_level;
  logic pick;

  // ==========================================================
  // Source decode and toggle
  always_comb begin
    pick = 1'b0;
    unique case (i_select)
      CLK_OUT_OFF: pick = 1'b0;
      CLK_OUT_SYS: pick = i_sys_tick;
      CLK_OUT_PHY: pick = i_phy_tick;
      CLK_OUT_AFE: pick = i_afe_tick;
    endcase
    next_out_level = out_level;
    if (!i_enable || i_select == CLK_OUT_OFF) begin
      next_out_level = 1'b0;
    end else if (pick) begin
      next_out_level = ~out_level;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      out_level <= 1'b0;
    end else begin
      out_level <= next_out_level;
    end
  end

  assign o_clock_out = out_level;
endmodule

// File: rtl/test_mode_control.sv
/*
  Test-mode control register: clock-test force, reset trip reference,
  watchdog clock gate, quiescent-current stop, warm-up bypass and clock
  output select. Assumes a CPU register port with one-cycle write and
  read strobes, a TAP test-enable level and a separate Test-Logic-Reset.
*/
`timescale 1ns/1ps
// How it works
// - While clock-test force is set the core runs from the undivided crystal, divider ignored.
// - A rising test enable forces clock-test force to one.
// - Reset trip ground ref holds until software clears it or power-on reset.
// - Watchdog clock stop gates the watchdog tick off while set.
// - Quiescent-current stop puts the device in stop mode while set.
// - Without warm-up bypass the chip reset waits the full crystal warm-up time.
// - A rising test enable sets the warm-up bypass bit.
// - Warm-up bypass clears on power-on reset or when software writes it clear, not on Test-Logic-Reset.
// - In test mode the selected prescaled clock goes to a pin divided by two.
// - Select 00 off, 01 system, 10 PHY, 11 analog front-end clock.
// - The test enable bit is read-only and mirrors the TAP buffer bit.
module test_mode_control (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_tap_logic_reset,
  // CPU register port
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [test_mode_pkg::REG_WIDTH-1:0] i_reg_wdata,
  output logic [test_mode_pkg::REG_WIDTH-1:0] o_reg_rdata,
  // TAP test enable (other domain)
  input wire logic i_tap_test_enable,
  // Clock sources
  input wire logic i_clock_divide_sel_hi,
  input wire logic i_clock_divide_sel_lo,
  input wire logic i_sys_tick,
  input wire logic i_phy_tick,
  input wire logic i_afe_tick,
  input wire logic i_watchdog_tick,
  // Controls out
  output logic o_crystal_direct,
  output logic [1:0] o_divide_sel,
  output logic o_reset_trip_ground_ref,
  output logic o_watchdog_tick,
  output logic o_stop_mode,
  output logic o_chip_reset,
  output logic o_clock_out
);
  import test_mode_pkg::*;

  // ==========================================================
  // Test-enable synchroniser, change taken when stages 2 and 3 agree
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic stage_agree;
  logic mirror;
  logic next_mirror;
  logic mirror_rise;

  always_comb begin
    next_sync = {sync[1:0], i_tap_test_enable};
    stage_agree = (sync[2] == sync[1]);
    next_mirror = mirror;
    if (stage_agree) begin
      next_mirror = sync[2];
    end
    // Edge, not level, so a later write may still clear the preset bits
    mirror_rise = next_mirror & ~mirror;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync <= 3'h0;
      mirror <= 1'b0;
    end else begin
      sync <= next_sync;
      mirror <= next_mirror;
    end
  end

  // ==========================================================
  // Write decode of the writable field bits
  ctrl_type write_view;

  always_comb begin
    write_view.clock_test_force = i_reg_wdata[BIT_CLOCK_TEST];
    write_view.reset_trip_ground_ref = i_reg_wdata[BIT_RESET_TRIP];
    write_view.watchdog_clock_stop = i_reg_wdata[BIT_WDOG_STOP];
    write_view.quiescent_current_stop = i_reg_wdata[BIT_QUIESCENT_STOP];
    write_view.warmup_bypass = i_reg_wdata[BIT_WARMUP_BYPASS];
    write_view.clock_output_select = i_reg_wdata[BIT_CLK_OUT_LO +: 2];
  end

  // ==========================================================
  // Control register
  ctrl_type ctrl;
  ctrl_type next_ctrl;

  always_comb begin
    next_ctrl = ctrl;
    // Writes are refused while the mirror is low
    if (i_reg_write && mirror) begin
      next_ctrl = write_view;
    end
    // Test-Logic-Reset spares the trip reference and bypass bits
    if (i_tap_logic_reset) begin
      next_ctrl.clock_test_force = 1'b0;
      next_ctrl.watchdog_clock_stop = 1'b0;
      next_ctrl.quiescent_current_stop = 1'b0;
      next_ctrl.clock_output_select = CLK_OUT_OFF;
    end
    // Entering test mode wins over a same-cycle write or Test-Logic-Reset
    if (mirror_rise) begin
      next_ctrl.clock_test_force = 1'b1;
      next_ctrl.warmup_bypass = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl <= RESET_VALUE[BIT_CLK_OUT_LO+1:BIT_CLOCK_TEST];
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================
  // Read data
  logic [15:0] rd_view;
  logic [15:0] next_rdata;

  always_comb begin
    rd_view = RESET_VALUE;
    rd_view[BIT_TEST_ENABLE] = mirror;
    rd_view[BIT_CLK_OUT_LO+1:BIT_CLOCK_TEST] = ctrl;
    next_rdata = i_reg_read ? (rd_view & (WRITE_MASK | 16'h0001)) : o_reg_rdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata <= RESET_VALUE;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Warm-up timer; bypass cuts it short at once
  logic [$clog2(WARMUP_CYCLES+1)-1:0] warm_count;
  logic [$clog2(WARMUP_CYCLES+1)-1:0] next_warm_count;
  logic next_chip_reset;

  always_comb begin
    next_warm_count = warm_count;
    if (warm_count != '0) begin
      next_warm_count = warm_count - 1'b1;
    end
    if (ctrl.warmup_bypass) begin
      next_warm_count = '0;
    end
    next_chip_reset = (next_warm_count != '0);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      warm_count <= WARMUP_CYCLES[$clog2(WARMUP_CYCLES+1)-1:0];
      o_chip_reset <= 1'b1;
    end else begin
      warm_count <= next_warm_count;
      o_chip_reset <= next_chip_reset;
    end
  end

  // ==========================================================
  // Clock path controls
  logic next_crystal_direct;
  logic [1:0] next_divide_sel;

  always_comb begin
    next_crystal_direct = ctrl.clock_test_force;
    next_divide_sel = {i_clock_divide_sel_hi, i_clock_divide_sel_lo};
    if (ctrl.clock_test_force) begin
      next_divide_sel = 2'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_crystal_direct <= 1'b0;
      o_divide_sel <= 2'h0;
    end else begin
      o_crystal_direct <= next_crystal_direct;
      o_divide_sel <= next_divide_sel;
    end
  end

  // ==========================================================
  // Trip reference, watchdog gate and stop mode
  logic next_reset_trip_ground_ref;
  logic next_watchdog_tick;
  logic next_stop_mode;

  always_comb begin
    next_reset_trip_ground_ref = ctrl.reset_trip_ground_ref;
    // Gating the tick, not the watchdog clock, keeps one clock domain
    next_watchdog_tick = i_watchdog_tick & ~ctrl.watchdog_clock_stop;
    next_stop_mode = ctrl.quiescent_current_stop;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reset_trip_ground_ref <= 1'b0;
      o_watchdog_tick <= 1'b0;
      o_stop_mode <= 1'b0;
    end else begin
      o_reset_trip_ground_ref <= next_reset_trip_ground_ref;
      o_watchdog_tick <= next_watchdog_tick;
      o_stop_mode <= next_stop_mode;
    end
  end

  // ==========================================================
  // Clock output pin
  clock_out_divider u_clock_out (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_enable(mirror),
    .i_select(ctrl.clock_output_select),
    .i_sys_tick(i_sys_tick),
    .i_phy_tick(i_phy_tick),
    .i_afe_tick(i_afe_tick),
    .o_clock_out(o_clock_out)
  );
endmodule

// File: rtl/test_mode_pkg.sv
/*
  Package for the test-mode control register block: bit positions,
  reset value, clock-output select codes and timing counts.
  Assumes a single 100 MHz core clock domain.
*/
package test_mode_pkg;

  // ==========================================================
  // Register layout
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned BIT_TEST_ENABLE = 0;
  localparam int unsigned BIT_CLOCK_TEST = 2;
  localparam int unsigned BIT_RESET_TRIP = 3;
  localparam int unsigned BIT_WDOG_STOP = 4;
  localparam int unsigned BIT_QUIESCENT_STOP = 5;
  localparam int unsigned BIT_WARMUP_BYPASS = 6;
  localparam int unsigned BIT_CLK_OUT_LO = 7;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] WRITE_MASK = 16'h01fc;

  // ==========================================================
  // Clock-output select codes
  localparam logic [1:0] CLK_OUT_OFF = 2'h0;
  localparam logic [1:0] CLK_OUT_SYS = 2'h1;
  localparam logic [1:0] CLK_OUT_PHY = 2'h2;
  localparam logic [1:0] CLK_OUT_AFE = 2'h3;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WARMUP_TIME_US = 100;
  localparam int unsigned WARMUP_CYCLES = (WARMUP_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;

  // ==========================================================
  // Control bits as a bundle
  typedef struct packed {
    logic [1:0] clock_output_select;
    logic warmup_bypass;
    logic quiescent_current_stop;
    logic watchdog_clock_stop;
    logic reset_trip_ground_ref;
    logic clock_test_force;
  } ctrl_type;

endpackage

// File: sim/test_mode_control_monitor.sv
/* Checker for the test-mode control block ports.
   Assumes it is bound onto the top with one core clock domain. */
`timescale 1ns/1ps
module test_mode_control_monitor (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_tap_logic_reset,
  // Register port
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [test_mode_pkg::REG_WIDTH-1:0] i_reg_wdata,
  input wire logic [test_mode_pkg::REG_WIDTH-1:0] o_reg_rdata,
  // Sources
  input wire logic i_tap_test_enable,
  input wire logic i_clock_divide_sel_hi,
  input wire logic i_clock_divide_sel_lo,
  input wire logic i_sys_tick,
  input wire logic i_phy_tick,
  input wire logic i_afe_tick,
  input wire logic i_watchdog_tick,
  // Controls
  input wire logic o_crystal_direct,
  input wire logic [1:0] o_divide_sel,
  input wire logic o_reset_trip_ground_ref,
  input wire logic o_watchdog_tick,
  input wire logic o_stop_mode,
  input wire logic o_chip_reset,
  input wire logic o_clock_out
);
  // ==========================================================
  // Assertions
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_crystal_div_zero: assert property (o_crystal_direct |-> o_divide_sel == 2'h0)
    else $error("divider not bypassed");
  a_enable_forces_clock: assert property ($rose(i_tap_test_enable) |-> ##[1:8] o_crystal_direct)
    else $error("clock test not forced");
  a_trip_set_cause: assert property ($rose(o_reset_trip_ground_ref) |->
    $past(i_reg_write, 2) && $past(i_reg_wdata[3], 2))
    else $error("trip bit set without write");
  a_wdog_gate_src: assert property (o_watchdog_tick |-> $past(i_watchdog_tick))
    else $error("watchdog tick without source");
  a_stop_set_cause: assert property ($rose(o_stop_mode) |->
    $past(i_reg_write, 2) && $past(i_reg_wdata[5], 2))
    else $error("stop mode without write");
  a_chip_reset_stays: assert property (!o_chip_reset |=> !o_chip_reset)
    else $error("chip reset came back");
  a_bypass_release: assert property ($rose(i_tap_test_enable) |-> ##[1:10] !o_chip_reset)
    else $error("warm-up not bypassed");
  a_rdata_holds: assert property (!$past(i_reg_read) |-> $stable(o_reg_rdata))
    else $error("read data moved");
  c_clock_out: cover property ($rose(o_clock_out));
  c_wdog_tick: cover property (o_watchdog_tick);
  c_stop: cover property (o_stop_mode);
endmodule

bind test_mode_control test_mode_control_monitor u_mon (.*);

// File: sim/test_mode_control_tb_top.sv
/* Self-checking bench for the test-mode control block.
   Assumes the package constants and a 100 MHz core clock. */
`timescale 1ns/1ps
module test_mode_control_tb_top;
  import test_mode_pkg::*;
  logic clk = 1'b0, srst = 1'b1, tlr = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ten = 1'b0;
  logic hi = 1'b0, lo = 1'b0, st = 1'b0, pt = 1'b0, at = 1'b0, wt = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic cd, rt, wo, sm, cr, co, prev;
  logic [1:0] ds;
  int num_errors = 0, samples_checked = 0, cyc = 0, mdl = 0, mir = 0, n, e;
  test_mode_control uut (.i_core_clk(clk), .i_srst(srst), .i_tap_logic_reset(tlr),
    .i_reg_write(wr_s), .i_reg_read(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_tap_test_enable(ten), .i_clock_divide_sel_hi(hi), .i_clock_divide_sel_lo(lo),
    .i_sys_tick(st), .i_phy_tick(pt), .i_afe_tick(at), .i_watchdog_tick(wt),
    .o_crystal_direct(cd), .o_divide_sel(ds), .o_reset_trip_ground_ref(rt),
    .o_watchdog_tick(wo), .o_stop_mode(sm), .o_chip_reset(cr), .o_clock_out(co));
  always #5 clk = ~clk;
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Model drops writes while the mirror is low
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    if (mir != 0) mdl = (d & WRITE_MASK) | 16'h0001;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd();
    @(posedge clk);
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_ctl();
    chk({11'h0, cd, rt, sm, ds}, {11'h0, mdl[2], mdl[3], mdl[5], mdl[2] ? 2'h0 : {hi, lo}});
  endtask
  task automatic wd(input logic on);
    logic p;
    p = 1'b0;
    repeat (6) begin
      @(posedge clk);
      wt <= 1'($urandom);
      #1 chk({15'h0, wo}, {15'h0, p & !on});
      p = wt;
    end
    @(posedge clk);
    wt <= 1'b0;
  endtask
  // ==========================================================
  // Sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h8d4657af));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd();
    chk(rdata, 16'h0000);
    chk({15'h0, cr}, 16'h0001);
    wr(16'h01fc);
    rd();
    chk(rdata, 16'h0000);
    @(posedge clk);
    ten <= 1'b1;
    hi <= 1'b1;
    repeat (8) @(posedge clk);
    mir = 1;
    mdl = 16'h0045;
    rd();
    chk(rdata, mdl[15:0]);
    chk({15'h0, cr}, 16'h0000);
    chk_ctl();
    for (int k = 0; k < 8; k++) begin
      hi <= 1'($urandom);
      lo <= 1'($urandom);
      wr(16'($urandom));
      rd();
      chk(rdata, mdl[15:0]);
      chk_ctl();
    end
    wr(16'h01fc);
    @(posedge clk);
    tlr <= 1'b1;
    @(posedge clk);
    tlr <= 1'b0;
    // Test-Logic-Reset clears bits 2, 4, 5, 7 and 8 only
    mdl = mdl & ~32'h000001b4;
    rd();
    chk(rdata, mdl[15:0]);
    wr(16'h0010);
    wd(1'b1);
    wr(16'h0000);
    wd(1'b0);
    // Ticks at coprime rates so a wrong select changes the count
    for (int s = 0; s < 4; s++) begin
      wr(16'(s) << 7);
      n = 0;
      e = 0;
      prev = co;
      for (int c = 0; c < 34; c++) begin
        @(posedge clk);
        st <= (c < 30) && (c % 2 == 0);
        pt <= (c < 30) && (c % 3 == 0);
        at <= (c < 30) && (c % 5 == 0);
        if (c < 30 && s != 0) e += int'(c % (s == 1 ? 2 : s == 2 ? 3 : 5) == 0);
        #1 if (co !== prev) n++;
        prev = co;
      end
      chk(16'(n), 16'(e));
    end
    @(posedge clk);
    srst <= 1'b1;
    ten <= 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd();
    chk(rdata, 16'h0000);
    n = 2;
    while (cr === 1'b1 && n < 10100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n > WARMUP_CYCLES - 8 && n < WARMUP_CYCLES + 8), 16'h0001);
    close_out();
  end
endmodule
